// *** design/dmas_slice.sv ***
`default_nettype none
// What this block does
// - Signed 27 by 18 bit two's complement multiply giving the full product.
// - A 48-bit accumulator adds each new result to its running value.
// - A dynamic input bypasses the multiplier; two 48-bit operands feed ALU.
// - SIMD mode splits the adder into two 24-bit or four 12-bit lanes.
// - Logic unit gives one of ten bitwise functions, chosen by a select.
// - Optional pre-adder combines two operands ahead of the multiplier.
// - Wide XOR over 96 input bits, in 12, 24, 48 or 96-bit segments.
// - Result is compared to a masked pattern and a match is flagged.
// - Pattern detect after the logic unit forms 96-bit wide logic functions.
// - Accumulator counts up or down by a given step on enabled edges.
module dmas_slice (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [29:0] a_in,
  input  wire logic [17:0] b_in,
  input  wire logic [47:0] c_in,
  input  wire logic [26:0] d_in,
  input  wire logic        mult_bypass,
  input  wire logic        ce_a,
  input  wire logic        ce_b,
  input  wire logic        ce_c,
  input  wire logic        ce_d,
  input  wire logic        ce_m,
  input  wire logic        ce_p,
  input  wire logic        rst_a,
  input  wire logic        rst_b,
  input  wire logic        rst_c,
  input  wire logic        rst_d,
  input  wire logic        rst_m,
  input  wire logic        rst_p,
  output logic      [47:0] p_out,
  output logic             match_out,
  output logic      [7:0]  xor_out
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [dmas_pkg::CTL_WIDTH-1:0] ctrl_reg;
  logic [47:0]                    pat_reg;
  logic [47:0]                    mask_reg;
  logic [31:0]                    rdata_reg;
  logic [47:0]                    p_reg;
  logic                           match_reg;
  logic [7:0]                     xor_reg;
  logic                           hit;
  logic [31:0]                    rd_next;
  logic                           wr_en;

  always_comb
  begin
    hit     = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (paddr)
      dmas_pkg::OFS_CTRL:    rd_next = {13'h0000, ctrl_reg};
      dmas_pkg::OFS_PAT_LO:  rd_next = pat_reg[31:0];
      dmas_pkg::OFS_PAT_HI:  rd_next = {16'h0000, pat_reg[47:32]};
      dmas_pkg::OFS_MASK_LO: rd_next = mask_reg[31:0];
      dmas_pkg::OFS_MASK_HI: rd_next = {16'h0000, mask_reg[47:32]};
      dmas_pkg::OFS_STATUS:  rd_next = {23'h00_0000, xor_reg, match_reg};
      dmas_pkg::OFS_RES_LO:  rd_next = p_reg[31:0];
      dmas_pkg::OFS_RES_HI:  rd_next = {16'h0000, p_reg[47:32]};
      default:               hit = 1'b0;
    endcase
  end

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign prdata  = rdata_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      rdata_reg <= rd_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= dmas_pkg::CTRL_RESET;
      pat_reg  <= {dmas_pkg::PAT_RESET[15:0], dmas_pkg::PAT_RESET};
      mask_reg <= {dmas_pkg::MASK_RESET[15:0], dmas_pkg::MASK_RESET};
    end
    else if (wr_en)
    begin
      unique case (paddr)
        dmas_pkg::OFS_CTRL:    ctrl_reg <= pwdata[dmas_pkg::CTL_WIDTH-1:0];
        dmas_pkg::OFS_PAT_LO:  pat_reg[31:0] <= pwdata;
        dmas_pkg::OFS_PAT_HI:  pat_reg[47:32] <= pwdata[15:0];
        dmas_pkg::OFS_MASK_LO: mask_reg[31:0] <= pwdata;
        dmas_pkg::OFS_MASK_HI: mask_reg[47:32] <= pwdata[15:0];
        default:               ;
      endcase
    end
  end

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  logic                 acc_en, sub_en, logic_en, pre_en, pre_sub, count_en;
  logic [4:0]           pipe_en;
  logic [1:0]           xor_w;
  dmas_pkg::dmas_simd_e simd;
  dmas_pkg::dmas_func_e func;

  assign acc_en   = ctrl_reg[dmas_pkg::CTL_ACC];
  assign sub_en   = ctrl_reg[dmas_pkg::CTL_SUB];
  assign logic_en = ctrl_reg[dmas_pkg::CTL_LOGIC];
  assign pre_en   = ctrl_reg[dmas_pkg::CTL_PRE];
  assign pre_sub  = ctrl_reg[dmas_pkg::CTL_PRESUB];
  assign count_en = ctrl_reg[dmas_pkg::CTL_COUNT];
  assign pipe_en  = ctrl_reg[dmas_pkg::CTL_PIPE +: 5];
  assign xor_w    = ctrl_reg[dmas_pkg::CTL_XORW +: 2];
  assign simd     = dmas_pkg::dmas_simd_e'(ctrl_reg[dmas_pkg::CTL_SIMD +: 2]);
  assign func     = dmas_pkg::dmas_func_e'(ctrl_reg[dmas_pkg::CTL_FUNC +: 4]);

  // ----------------------------------------
  // Operand stages
  // ----------------------------------------
  logic [29:0] a_q;
  logic [17:0] b_q;
  logic [47:0] c_q;
  logic [26:0] d_q;

  dmas_stage #(.W(30)) u_a (.pclk(pclk), .presetn(presetn),
    .use_reg(pipe_en[dmas_pkg::PIPE_A]), .ce(ce_a), .srst(rst_a), .d(a_in), .q(a_q));
  dmas_stage #(.W(18)) u_b (.pclk(pclk), .presetn(presetn),
    .use_reg(pipe_en[dmas_pkg::PIPE_B]), .ce(ce_b), .srst(rst_b), .d(b_in), .q(b_q));
  dmas_stage #(.W(48)) u_c (.pclk(pclk), .presetn(presetn),
    .use_reg(pipe_en[dmas_pkg::PIPE_C]), .ce(ce_c), .srst(rst_c), .d(c_in), .q(c_q));
  dmas_stage #(.W(27)) u_d (.pclk(pclk), .presetn(presetn),
    .use_reg(pipe_en[dmas_pkg::PIPE_D]), .ce(ce_d), .srst(rst_d), .d(d_in), .q(d_q));

  // ----------------------------------------
  // Pre-adder and multiplier
  // ----------------------------------------
  // Pre-adder wraps at 27 bits; callers keep the sum in range
  logic [26:0] pre_sum;
  logic [26:0] mul_a;
  logic [44:0] prod;
  logic [44:0] m_q;

  assign pre_sum = pre_sub ? a_q[26:0] - d_q : a_q[26:0] + d_q;
  assign mul_a   = pre_en ? pre_sum : a_q[26:0];
  assign prod    = 45'($signed(mul_a) * $signed(b_q));

  dmas_stage #(.W(45)) u_m (.pclk(pclk), .presetn(presetn),
    .use_reg(pipe_en[dmas_pkg::PIPE_M]), .ce(ce_m), .srst(rst_m), .d(prod), .q(m_q));

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  logic [47:0] x_sel;
  logic [47:0] z_sel;
  logic [47:0] w_sel;

  always_comb
  begin
    if (count_en)
      x_sel = 48'h0000_0000_0000;
    else if (mult_bypass)
      x_sel = {a_q, b_q};
    else
      x_sel = {{3{m_q[44]}}, m_q};
  end

  assign z_sel = c_q;
  assign w_sel = (acc_en | count_en) ? p_reg : 48'h0000_0000_0000;

  // ----------------------------------------
  // SIMD adder: result = w +/- (x + z) per lane
  // ----------------------------------------
  logic [47:0] sum48;
  logic [47:0] sum24;
  logic [47:0] sum12;
  logic [47:0] alu_res;

  assign sum48 = sub_en ? w_sel - (x_sel + z_sel) : w_sel + x_sel + z_sel;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_l12
      assign sum12[gi*12 +: 12] = sub_en ?
        w_sel[gi*12 +: 12] - (x_sel[gi*12 +: 12] + z_sel[gi*12 +: 12]) :
        w_sel[gi*12 +: 12] + x_sel[gi*12 +: 12] + z_sel[gi*12 +: 12];
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_l24
      assign sum24[gi*24 +: 24] = sub_en ?
        w_sel[gi*24 +: 24] - (x_sel[gi*24 +: 24] + z_sel[gi*24 +: 24]) :
        w_sel[gi*24 +: 24] + x_sel[gi*24 +: 24] + z_sel[gi*24 +: 24];
    end
  endgenerate

  // ----------------------------------------
  // Logic unit
  // ----------------------------------------
  logic [47:0] logic_res;

  always_comb
  begin
    case (func)
      dmas_pkg::LF_AND:      logic_res = x_sel & z_sel;
      dmas_pkg::LF_OR:       logic_res = x_sel | z_sel;
      dmas_pkg::LF_XOR:      logic_res = x_sel ^ z_sel;
      dmas_pkg::LF_XNOR:     logic_res = ~(x_sel ^ z_sel);
      dmas_pkg::LF_NAND:     logic_res = ~(x_sel & z_sel);
      dmas_pkg::LF_NOR:      logic_res = ~(x_sel | z_sel);
      dmas_pkg::LF_X_ANDN_Z: logic_res = x_sel & ~z_sel;
      dmas_pkg::LF_X_ORN_Z:  logic_res = x_sel | ~z_sel;
      dmas_pkg::LF_NX_AND_Z: logic_res = ~x_sel & z_sel;
      dmas_pkg::LF_NX_OR_Z:  logic_res = ~x_sel | z_sel;
      // Unused select codes give zero rather than a stale function
      default:               logic_res = 48'h0000_0000_0000;
    endcase
  end

  always_comb
  begin
    if (logic_en)
      alu_res = logic_res;
    else
    begin
      case (simd)
        dmas_pkg::SIMD_TWO24:  alu_res = sum24;
        dmas_pkg::SIMD_FOUR12: alu_res = sum12;
        default:               alu_res = sum48;
      endcase
    end
  end

  // ----------------------------------------
  // Wide XOR and pattern detect
  // ----------------------------------------
  logic [95:0] xor_in;
  logic [7:0]  par12;
  logic [7:0]  xor_next;
  logic        match_next;

  assign xor_in = {z_sel, x_sel};

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_par
      assign par12[gi] = ^xor_in[gi*12 +: 12];
    end
  endgenerate

  always_comb
  begin
    xor_next = 8'h00;
    unique case (xor_w)
      2'h0: xor_next = par12;
      2'h1:
      begin
        for (int i = 0; i < 4; i++)
          xor_next[i] = par12[2*i] ^ par12[2*i+1];
      end
      2'h2:
      begin
        xor_next[0] = ^par12[3:0];
        xor_next[1] = ^par12[7:4];
      end
      2'h3: xor_next[0] = ^par12;
    endcase
  end

  // Mask bit high means the bit is ignored; on logic results this
  // gives a 96-input wide logic function
  assign match_next = &(~(alu_res ^ pat_reg) | mask_reg);

  // ----------------------------------------
  // Result stage (always registered: it closes the accumulator loop)
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p_reg     <= 48'h0000_0000_0000;
      match_reg <= 1'b0;
      xor_reg   <= 8'h00;
    end
    else if (rst_p)
    begin
      p_reg     <= 48'h0000_0000_0000;
      match_reg <= 1'b0;
      xor_reg   <= 8'h00;
    end
    else if (ce_p)
    begin
      p_reg     <= alu_res;
      match_reg <= match_next;
      xor_reg   <= xor_next;
    end
  end

  assign p_out     = p_reg;
  assign match_out = match_reg;
  assign xor_out   = xor_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic plain_add;
  assign plain_add = ce_p & ~rst_p & ~logic_en & ~sub_en & ~count_en;

  mult_product_a: assert property (pipe_en[dmas_pkg::PIPE_M] && ce_m && !rst_m && !wr_en
    |=> $signed(m_q) == $signed($past(mul_a)) * $signed($past(b_q)))
    else $error("product stage does not hold signed product");
  acc_running_a: assert property (plain_add && acc_en && simd == dmas_pkg::SIMD_ONE48
    |=> p_reg == 48'($past(p_reg) + $past(x_sel) + $past(z_sel)))
    else $error("accumulator did not add to running value");
  bypass_path_a: assert property (mult_bypass && !count_en |-> x_sel == {a_q, b_q})
    else $error("bypass operand not taken from a and b");
  simd_lane_a: assert property (plain_add && !acc_en && simd == dmas_pkg::SIMD_FOUR12
    |=> p_reg[23:12] == 12'($past(x_sel[23:12]) + $past(z_sel[23:12])))
    else $error("carry leaked into 12-bit lane");
  logic_and_a: assert property (ce_p && !rst_p && logic_en && func == dmas_pkg::LF_AND
    |=> p_reg == ($past(x_sel) & $past(z_sel)))
    else $error("logic unit AND result wrong");
  preadd_sum_a: assert property (pre_en && !pre_sub
    |-> mul_a == 27'(a_q[26:0] + d_q))
    else $error("pre-adder sum wrong");
  xor_full_a: assert property (ce_p && !rst_p && xor_w == 2'h3
    |=> xor_reg == {7'h00, ^$past(xor_in)})
    else $error("96-bit xor reduction wrong");
  pattern_match_a: assert property (ce_p && !rst_p
    |=> match_reg == ((($past(alu_res) ^ $past(pat_reg)) & ~$past(mask_reg)) == 48'h0))
    else $error("pattern match flag wrong");
  wide_logic_a: assert property (ce_p && !rst_p && logic_en && func == dmas_pkg::LF_AND
    && mask_reg == 48'h0 && pat_reg == '1 |=> match_reg == (&$past(xor_in)))
    else $error("96-bit wide AND through pattern detect wrong");
  count_step_a: assert property (ce_p && !rst_p && count_en && sub_en && !logic_en
    && simd == dmas_pkg::SIMD_ONE48 |=> p_reg == 48'($past(p_reg) - $past(c_q)))
    else $error("down count did not step by c");
  stage_hold_a: assert property (!ce_p && !rst_p |=> $stable(p_reg) ##1 1'b1)
    else $error("result stage changed without enable");
  stage_reset_a: assert property (rst_p |=> p_reg == 48'h0 && !match_reg)
    else $error("result stage not cleared by its reset");

  acc_seen_c:   cover property (plain_add && acc_en ##1 plain_add && acc_en);
  simd_seen_c:  cover property (ce_p && simd == dmas_pkg::SIMD_TWO24 && !logic_en);
  match_seen_c: cover property (ce_p ##1 match_reg);
  count_seen_c: cover property (ce_p && count_en ##1 ce_p && count_en);
endmodule
`default_nettype wire

// *** design/dmas_stage.sv ***
`default_nettype none
// Optional pipeline stage: registered when enabled, transparent otherwise
module dmas_stage #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         use_reg,
  input  wire logic         ce,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_reg <= '0;
    else if (srst)
      q_reg <= '0;
    else if (ce)
      q_reg <= d;
  end

  assign q = use_reg ? q_reg : d;
endmodule
`default_nettype wire

// *** include/dmas_pkg.sv ***
`default_nettype none
package dmas_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PAT_LO  = 8'h04;
  localparam logic [7:0] OFS_PAT_HI  = 8'h08;
  localparam logic [7:0] OFS_MASK_LO = 8'h0c;
  localparam logic [7:0] OFS_MASK_HI = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_RES_LO  = 8'h18;
  localparam logic [7:0] OFS_RES_HI  = 8'h1c;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_ACC     = 0;
  localparam int CTL_SUB     = 1;
  localparam int CTL_SIMD    = 2;
  localparam int CTL_LOGIC   = 4;
  localparam int CTL_FUNC    = 5;
  localparam int CTL_XORW    = 9;
  localparam int CTL_PIPE    = 11;
  localparam int CTL_PRE     = 16;
  localparam int CTL_PRESUB  = 17;
  localparam int CTL_COUNT   = 18;
  localparam int CTL_WIDTH   = 19;
  // Operand and product stages registered after reset
  localparam logic [CTL_WIDTH-1:0] CTRL_RESET = 19'h0_f800;
  localparam logic [31:0] PAT_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;

  // Pipe enable bit order within the pipe field
  localparam int PIPE_A = 0;
  localparam int PIPE_B = 1;
  localparam int PIPE_C = 2;
  localparam int PIPE_D = 3;
  localparam int PIPE_M = 4;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int A_W    = 30;
  localparam int B_W    = 18;
  localparam int MUL_AW = 27;
  localparam int PROD_W = 45;
  localparam int P_W    = 48;
  localparam int XOR_W  = 8;

  typedef enum logic [1:0] {SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12} dmas_simd_e;
  typedef enum logic [3:0] {
    LF_AND, LF_OR, LF_XOR, LF_XNOR, LF_NAND,
    LF_NOR, LF_X_ANDN_Z, LF_X_ORN_Z, LF_NX_AND_Z, LF_NX_OR_Z
  } dmas_func_e;
endpackage
`default_nettype wire

// *** tb/dmas_fabric.sv ***
`default_nettype none
module dmas_fabric (
  input  wire logic        pclk,
  input  wire logic        req,
  input  wire logic [29:0] a,
  input  wire logic [17:0] b,
  input  wire logic [47:0] c,
  input  wire logic [26:0] d,
  output logic      [29:0] a_in,
  output logic      [17:0] b_in,
  output logic      [47:0] c_in,
  output logic      [26:0] d_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Known start value: unknown operands would poison every registered stage after reset
  logic [122:0] idle_reg = '0;
  // Between requests the operands toggle every cycle, so stale data never looks valid
  always @(posedge pclk)
  begin
    idle_reg <= req ? ~{a, b, c, d} : ~idle_reg;
  end
  assign {a_in, b_in, c_in, d_in} = req ? {a, b, c, d} : idle_reg;
endmodule
`default_nettype wire

// *** tb/dmas_slice_tb_top.sv ***
`default_nettype none
module dmas_slice_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h087a;
  logic        pready, pslverr, match_out, req = 1'b0, byp = 1'b1;
  logic [29:0] fa = 30'h0, a_in;
  logic [17:0] fb = 18'h0, b_in;
  logic [47:0] fc = 48'h0, c_in, p_out, pm = 48'h0, pat = 48'h0, mask = 48'hffff_ffff_ffff;
  logic [26:0] fd = 27'h0, d_in;
  logic [5:0]  ce = 6'h3f, rs = 6'h0;
  logic [7:0]  xor_out;
  logic [18:0] ctrl = 19'h0_f800;
  logic [18:0] modes [16] = '{19'h0_0000, 19'h0_0002, 19'h0_0001, 19'h0_0006, 19'h0_0009,
    19'h0_0004, 19'h0_0008, 19'h1_0000, 19'h3_0000, 19'h1_0001, 19'h4_0000, 19'h4_0002,
    19'h0_0200, 19'h0_0400, 19'h0_0600, 19'h0_000c};
  int          miscompares = 0, compares = 0;

  always #5 pclk = ~pclk;

  dmas_slice i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .a_in(a_in), .b_in(b_in), .c_in(c_in), .d_in(d_in),
    .mult_bypass(byp), .ce_a(ce[0]), .ce_b(ce[1]), .ce_c(ce[2]), .ce_d(ce[3]),
    .ce_m(ce[4]), .ce_p(ce[5]), .rst_a(rs[0]), .rst_b(rs[1]), .rst_c(rs[2]), .rst_d(rs[3]),
    .rst_m(rs[4]), .rst_p(rs[5]), .p_out(p_out), .match_out(match_out), .xor_out(xor_out));
  dmas_fabric i_fab (.pclk(pclk), .req(req), .a(fa), .b(fb), .c(fc), .d(fd),
    .a_in(a_in), .b_in(b_in), .c_in(c_in), .d_in(d_in));

  // ----------------------------------------
  // Expected values
  // ----------------------------------------
  function automatic logic [31:0] nxt();
    seed = seed[0] ? ((seed >> 1) ^ 32'h8020_0003) : (seed >> 1);
    return seed;
  endfunction
  function automatic logic [47:0] get_x(input logic [18:0] ct, input logic [29:0] a,
    input logic [17:0] b, input logic [26:0] d, input logic bp);
    logic        [26:0] pre;
    logic signed [44:0] prod;
    pre = ct[16] ? (ct[17] ? a[26:0] - d : a[26:0] + d) : a[26:0];
    prod = $signed(pre) * $signed(b);
    if (ct[18])
      return 48'h0;
    return bp ? {a, b} : {{3{prod[44]}}, prod};
  endfunction
  function automatic logic [47:0] exp_p(input logic [18:0] ct, input logic [47:0] x,
    input logic [47:0] z, input logic [47:0] p);
    logic [47:0] w, m, r;
    int          n;
    if (ct[4])
    begin
      case (ct[8:5])
        4'd0: return x & z;
        4'd1: return x | z;
        4'd2: return x ^ z;
        4'd3: return ~(x ^ z);
        4'd4: return ~(x & z);
        4'd5: return ~(x | z);
        4'd6: return x & ~z;
        4'd7: return x | ~z;
        4'd8: return ~x & z;
        4'd9: return ~x | z;
        default: return 48'h0;
      endcase
    end
    n = (ct[3:2] == 2'd1) ? 24 : ((ct[3:2] == 2'd2) ? 12 : 48);
    m = (48'h1 << n) - 48'h1;
    w = (ct[0] | ct[18]) ? p : 48'h0;
    r = 48'h0;
    // Each lane is summed alone and masked, so no carry reaches the next lane
    for (int i = 0; i < 48; i += n)
      r = r | (((ct[1] ? (w >> i) - ((x >> i) + (z >> i)) : (w >> i) + (x >> i) + (z >> i))
        & m) << i);
    return r;
  endfunction
  function automatic logic [7:0] exp_x(input logic [18:0] ct, input logic [47:0] x,
    input logic [47:0] z);
    logic [95:0] v;
    logic [7:0]  q;
    v = {z, x};
    for (int i = 0; i < 8; i++)
      q[i] = ^v[12*i +: 12];
    case (ct[10:9])
      2'd0: return q;
      2'd1: return {4'h0, q[7] ^ q[6], q[5] ^ q[4], q[3] ^ q[2], q[1] ^ q[0]};
      2'd2: return {6'h0, ^q[7:4], ^q[3:0]};
      default: return {7'h0, ^q};
    endcase
  endfunction

  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({47'h0, got}, {47'h0, exp}, what);
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad, wd, r, e);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h0, r, e);
    chk_val({16'h0, r}, {16'h0, exp}, "read data");
    chk_flag(e, eexp, "slave error");
  endtask
  task automatic set(input logic [18:0] v);
    ctrl = v;
    wreg(dmas_pkg::OFS_CTRL, {13'h0, v});
  endtask
  task automatic op(input logic bp, input logic [29:0] a, input logic [17:0] b,
    input logic [47:0] c, input logic [26:0] d);
    logic [47:0] x, e;
    x = get_x(ctrl, a, b, d, bp);
    e = exp_p(ctrl, x, c, pm);
    @(posedge pclk);
    req <= 1'b1;
    byp <= bp;
    fa <= a;
    fb <= b;
    fc <= c;
    fd <= d;
    ce[5] <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    ce[5] <= 1'b0;
    #1;
    chk_val(p_out, e, "result");
    chk_flag(match_out, ((e ^ pat) & ~mask) == 48'h0, "match");
    chk_val({40'h0, xor_out}, {40'h0, exp_x(ctrl, x, c)}, "xor");
    pm = e;
  endtask
  task automatic rop();
    logic [31:0] r0, r1, r2, r3, r4;
    r0 = nxt();
    r1 = nxt();
    r2 = nxt();
    r3 = nxt();
    r4 = nxt();
    op(r0[31], r1[29:0], r2[17:0], {r3[15:0], r4}, r0[26:0]);
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(dmas_pkg::OFS_CTRL, 32'h0000_f800, 1'b0);
    rchk(dmas_pkg::OFS_MASK_LO, 32'hffff_ffff, 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    // Operand stages hold the first set while the second one is on the pins
    set(19'h0_3800);
    @(posedge pclk);
    req <= 1'b1;
    fa <= 30'h1111;
    fb <= 18'h2222;
    fc <= 48'h3333;
    @(posedge pclk);
    fa <= 30'h0;
    ce[2:0] <= 3'h0;
    ce[5] <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    ce <= 6'h1f;
    #1;
    chk_val(p_out, {30'h1111, 18'h2222} + 48'h3333, "latency");
    repeat (2) @(posedge pclk);
    chk_val(p_out, {30'h1111, 18'h2222} + 48'h3333, "hold");
    rs[5] <= 1'b1;
    ce[5] <= 1'b1;
    @(posedge pclk);
    rs[5] <= 1'b0;
    ce[5] <= 1'b0;
    #1;
    chk_val(p_out, 48'h0, "stage reset");
    mask = 48'hffff_ffff_fff0;
    wreg(dmas_pkg::OFS_MASK_LO, 32'hffff_fff0);
    wreg(dmas_pkg::OFS_MASK_HI, 32'h0000_ffff);
    set(19'h0_0000);
    op(1'b0, 30'h0400_0000, 18'h2_0000, 48'h0, 27'h0);
    op(1'b1, 30'h0, 18'h0, 48'h1230, 27'h0);
    op(1'b1, 30'h0, 18'h0, 48'h5, 27'h0);
    rchk(dmas_pkg::OFS_STATUS, 32'h0, 1'b0);
    wreg(dmas_pkg::OFS_RES_LO, 32'hffff_ffff);
    rchk(dmas_pkg::OFS_RES_LO, 32'h5, 1'b0);
    for (int k = 0; k < 27; k++)
    begin
      set(k < 16 ? modes[k] : 19'h0_0010 | 19'((k - 16) << 5));
      repeat (3) rop();
    end
    // Empty mask with an all-ones pattern turns the detector into a 96-input AND
    mask = 48'h0;
    pat = 48'hffff_ffff_ffff;
    wreg(dmas_pkg::OFS_MASK_LO, 32'h0000_0000);
    wreg(dmas_pkg::OFS_MASK_HI, 32'h0000_0000);
    wreg(dmas_pkg::OFS_PAT_LO, 32'hffff_ffff);
    wreg(dmas_pkg::OFS_PAT_HI, 32'h0000_ffff);
    rchk(dmas_pkg::OFS_PAT_HI, 32'h0000_ffff, 1'b0);
    set(19'h0_0010);
    op(1'b1, 30'h3fff_ffff, 18'h3_ffff, 48'hffff_ffff_ffff, 27'h0);
    repeat (4) rop();
    conclude();
  end
endmodule
`default_nettype wire
